// ==== trc_pkg.sv ====
// Constants and types shared by the trigger rate counter block
package trc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int HALF_SEC_NS = 500_000_000;
    localparam int HALF_SEC_CYC = HALF_SEC_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    localparam int NUM_CNT = 5;
    localparam int CNT_W = 16;
    localparam int STORE_STEPS = 6;
    // ------------------------------------------------------------
    // RAM layout, byte index and 16-bit word index
    // ------------------------------------------------------------
    localparam int RAM_BYTES = 32;
    localparam logic [4:0] IDX_ENABLE_LAST = 5'h07;
    localparam logic [4:0] IDX_RATE_FIRST = 5'h08;
    localparam logic [4:0] IDX_RATE_LAST = 5'h11;
    localparam logic [4:0] IDX_DAC_FIRST = 5'h12;
    localparam logic [4:0] IDX_PRESCALE = 5'h1C;
    localparam logic [4:0] IDX_OVF = 5'h1D;
    localparam logic [4:0] IDX_CRC_ERR = 5'h1E;
    localparam logic [4:0] IDX_SPARE = 5'h1F;
    localparam logic [3:0] WORD_RATE_FIRST = 4'h4;
    localparam logic [3:0] WORD_OVF = 4'hE;
    localparam logic [7:0] PRESCALE_RST = 8'h00;
    // ------------------------------------------------------------
    // Own registers, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_IRQ_STAT = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    localparam logic [7:0] OFF_STATE = 8'h88;
    localparam int IRQ_W = 3;
    localparam int IRQ_STORED = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_RESTART = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ------------------------------------------------------------
    // Main state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_WAIT_LOCK = 3'h1,
        ST_RUN = 3'h2,
        ST_STORE = 3'h4
    } trc_state_t;
endpackage

// ==== trc_rate_counter.sv ====
// One synchronised, saturating 16-bit trigger counter
`timescale 1ns/1ps
module trc_rate_counter
    import trc_pkg::*;
#(
    parameter int CW = CNT_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trig,
    input wire logic clear,
    output logic [CW-1:0] count,
    output logic ovf
);
    initial
    begin
        if (CW < 2)
            $error("counter width too small");
    end

    logic s1;
    logic s2;
    logic s3;
    logic level;
    wire agree = (s2 == s3);
    wire rise = agree & s2 & ~level;
    wire at_max = (count == {CW{1'b1}});

    // ------------------------------------------------------------
    // Input sync and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= trig;
            s2 <= s1;
            s3 <= s2;
            if (agree)
                level <= s2;
        end
    end

    // ------------------------------------------------------------
    // Count
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= '0;
            ovf <= 1'b0;
        end
        else if (clear)
        begin
            count <= {{(CW-1){1'b0}}, rise};
            ovf <= 1'b0;
        end
        else if (rise)
        begin
            if (at_max)
                ovf <= 1'b1;
            else
                count <= count + 1'b1;
        end
    end

    a_ovf_holds_max: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf |-> at_max)
        else $error("overflow flag without saturated count");
    a_one_per_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (!clear && !rise) |=> $stable(count))
        else $error("count moved without a rising edge");
endmodule

// ==== trc_dpram.sv ====
// 32-byte RAM, byte-wide port A and 16-bit port B
`timescale 1ns/1ps
module trc_dpram
    import trc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] a_addr,
    input wire logic a_we,
    input wire logic [7:0] a_din,
    output logic [7:0] a_dout,
    input wire logic [3:0] b_addr,
    input wire logic [1:0] b_we,
    input wire logic [15:0] b_din,
    output logic [15:0] b_dout
);
    logic [7:0] mem [RAM_BYTES];
    wire [4:0] b_lo = {b_addr, 1'b0};
    wire [4:0] b_hi = {b_addr, 1'b1};

    // ------------------------------------------------------------
    // Both ports, read before write
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < RAM_BYTES; i++)
                mem[i] <= 8'h00;
            a_dout <= 8'h00;
            b_dout <= 16'h0000;
        end
        else
        begin
            a_dout <= mem[a_addr];
            b_dout <= {mem[b_hi], mem[b_lo]};
            if (a_we)
                mem[a_addr] <= a_din;
            if (b_we[0])
                mem[b_lo] <= b_din[7:0];
            if (b_we[1])
                mem[b_hi] <= b_din[15:8];
        end
    end
endmodule

// ==== trc_top.sv ====
// Trigger rate counter with period timebase, RAM and AXI4-Lite slave
`timescale 1ns/1ps
//
// Contract
// - Four patch counters plus one coincidence counter
// - Counters 16 bits, count until period end
// - Period is (y+1)/2 seconds from prescale
// - Period spans 500 ms to 128 s
// - All five counters share one timing
// - Config change clears counters, restarts period
// - Store only complete uninterrupted periods
// - Exceeding 16 bits sets overflow flag
// - Everything timed by dividing the one clock
// - Operate only after clock ready indication
// - Settings and results live in 32-byte RAM
// - Two ports, byte words and 16-bit words
// - Counts at bytes 8-17, low byte first
// - Result and overflow bytes read-only externally
module trc_top
    import trc_pkg::*;
#(
    parameter int HALF_SEC_CYCLES = HALF_SEC_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] trig_patch,
    input wire logic trig_coinc,
    input wire logic clk_locked,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    localparam int HC_W = $clog2(HALF_SEC_CYCLES);
    localparam logic [HC_W-1:0] HALF_LAST = HC_W'(HALF_SEC_CYCLES - 1);

    initial
    begin
        if (HALF_SEC_CYCLES < 2 * STORE_STEPS)
            $error("half-second count too short for store");
    end

    // ------------------------------------------------------------
    // Address decode functions
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = !a[7] || (a[6:2] <= OFF_STATE[6:2]);
    endfunction

    function automatic logic is_config(input logic [4:0] i);
        is_config = (i <= IDX_ENABLE_LAST) ||
            (i >= IDX_DAC_FIRST && i <= IDX_PRESCALE);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    trc_state_t state;
    trc_state_t next_state;
    logic lk1;
    logic lk2;
    logic lk3;
    logic lock_ok;
    logic [HC_W-1:0] half_cnt;
    logic [7:0] per_cnt;
    logic [7:0] prescale;
    logic [2:0] store_idx;
    logic [CNT_W-1:0] cnt [NUM_CNT];
    logic [NUM_CNT-1:0] ovf;
    logic [CNT_W-1:0] snap [NUM_CNT];
    logic [NUM_CNT-1:0] snap_ovf;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic rd_pend;
    logic [7:0] ar_q;
    logic [7:0] ram_a_dout;
    logic [15:0] ram_b_dout;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    wire [NUM_CNT-1:0] trig_all = {trig_coinc, trig_patch};
    wire active = (state == ST_RUN) || (state == ST_STORE);
    wire tick = (half_cnt == HALF_LAST);
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_hold & w_hold & ~s_axi_bvalid & ~ar_take;
    wire [4:0] aw_idx = aw_q[6:2];
    wire wr_ram = do_write & !aw_q[7] & wstrb_q;
    wire ram_a_we = wr_ram & (is_config(aw_idx) || aw_idx == IDX_SPARE);
    wire restart = active & wr_ram & is_config(aw_idx);
    wire period_end = (state == ST_RUN) & tick & (per_cnt == prescale)
        & ~restart;
    wire clr_cnt = ~active | period_end | restart;
    wire store_last = (state == ST_STORE) &&
        (store_idx == 3'(STORE_STEPS - 1));
    wire own_wr = do_write & aw_q[7] & wstrb_q;
    wire stat_wr = own_wr && (aw_q[6:2] == OFF_IRQ_STAT[6:2]);
    wire mask_wr = own_wr && (aw_q[6:2] == OFF_IRQ_MASK[6:2]);
    wire [4:0] ram_a_addr = do_write ? aw_idx : s_axi_araddr[6:2];
    wire store_ovf = (store_idx == 3'(NUM_CNT));
    wire [2:0] snap_sel = store_ovf ? 3'h0 : store_idx;
    wire [3:0] ram_b_addr = (state != ST_STORE) ? WORD_RATE_FIRST :
        store_ovf ? WORD_OVF : WORD_RATE_FIRST + {1'b0, store_idx};
    wire [1:0] ram_b_we = (state != ST_STORE) ? 2'h0 :
        store_ovf ? 2'h2 : 2'h3;
    wire [15:0] ram_b_din = store_ovf ?
        {3'h0, snap_ovf, 8'h00} : snap[snap_sel];
    wire [IRQ_W-1:0] irq_ev = {restart, period_end & (|ovf), store_last};
    wire [IRQ_W-1:0] irq_clr = stat_wr ? wdata_q[IRQ_W-1:0] : IRQ_RST;
    wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
    wire [7:0] own_rd = (ar_q[6:2] == OFF_IRQ_STAT[6:2]) ?
        {5'h00, irq_stat} : (ar_q[6:2] == OFF_IRQ_MASK[6:2]) ?
        {5'h00, irq_mask} : {6'h00, lock_ok, active};
    wire [7:0] rd_byte = !addr_mapped(ar_q) ? 8'h00 :
        ar_q[7] ? own_rd : ram_a_dout;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_WAIT_LOCK:
                if (lock_ok)
                    next_state = ST_RUN;
            ST_RUN:
                if (!lock_ok)
                    next_state = ST_WAIT_LOCK;
                else if (period_end)
                    next_state = ST_STORE;
            ST_STORE:
                if (store_last)
                    next_state = lock_ok ? ST_RUN : ST_WAIT_LOCK;
            default:
                next_state = ST_WAIT_LOCK;
        endcase
    end

    // ------------------------------------------------------------
    // Clock ready sync and main state
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lk1 <= 1'b0;
            lk2 <= 1'b0;
            lk3 <= 1'b0;
            lock_ok <= 1'b0;
            state <= ST_WAIT_LOCK;
        end
        else
        begin
            lk1 <= clk_locked;
            lk2 <= lk1;
            lk3 <= lk2;
            if (lk2 == lk3)
                lock_ok <= lk2;
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Period timebase
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !active || restart)
        begin
            half_cnt <= '0;
            per_cnt <= 8'h00;
        end
        else
        begin
            half_cnt <= tick ? '0 : half_cnt + 1'b1;
            if (tick)
                per_cnt <= period_end ? 8'h00 : per_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Counters and snapshot
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_CNT; g++)
        begin : g_cnt
            trc_rate_counter #(.CW(CNT_W)) u_cnt (
                .aclk(aclk),
                .aresetn(aresetn),
                .trig(trig_all[g]),
                .clear(clr_cnt),
                .count(cnt[g]),
                .ovf(ovf[g])
            );
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < NUM_CNT; i++)
                snap[i] <= '0;
            snap_ovf <= '0;
            store_idx <= 3'h0;
        end
        else
        begin
            if (period_end)
            begin
                for (int i = 0; i < NUM_CNT; i++)
                    snap[i] <= cnt[i];
                snap_ovf <= ovf;
            end
            store_idx <= (state == ST_STORE) ? store_idx + 3'h1 : 3'h0;
        end
    end

    trc_dpram u_ram (
        .aclk(aclk),
        .aresetn(aresetn),
        .a_addr(ram_a_addr),
        .a_we(ram_a_we),
        .a_din(wdata_q),
        .a_dout(ram_a_dout),
        .b_addr(ram_b_addr),
        .b_we(ram_b_we),
        .b_din(ram_b_din),
        .b_dout(ram_b_dout)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave, interrupts and prescale shadow
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            rd_pend <= 1'b0;
            ar_q <= 8'h00;
            irq_stat <= IRQ_RST;
            irq_mask <= IRQ_RST;
            irq <= 1'b0;
            prescale <= PRESCALE_RST;
        end
        else
        begin
            if (aw_take)
                aw_q <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_q <= s_axi_wdata[7:0];
                wstrb_q <= s_axi_wstrb[0];
            end
            aw_hold <= (aw_hold | aw_take) & ~do_write;
            w_hold <= (w_hold | w_take) & ~do_write;
            s_axi_awready <= ~((aw_hold | aw_take) & ~do_write);
            s_axi_wready <= ~((w_hold | w_take) & ~do_write);
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(aw_q) ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (ar_take)
                ar_q <= s_axi_araddr;
            rd_pend <= ar_take;
            s_axi_arready <= ~(ar_take | rd_pend | s_axi_rvalid) |
                (s_axi_rvalid & s_axi_rready);
            if (rd_pend)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= addr_mapped(ar_q) ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            irq_stat <= next_irq_stat;
            if (mask_wr)
                irq_mask <= wdata_q[IRQ_W-1:0];
            irq <= |(next_irq_stat & (mask_wr ? wdata_q[IRQ_W-1:0] :
                irq_mask));
            if (ram_a_we && aw_idx == IDX_PRESCALE)
                prescale <= wdata_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [39:0] per_cyc;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr_cnt)
            per_cyc <= 40'h00_0000_0000;
        else
            per_cyc <= per_cyc + 40'h00_0000_0001;
    end

    a_wait_for_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_WAIT_LOCK && !lock_ok) |=> state == ST_WAIT_LOCK)
        else $error("left wait state without clock ready");
    a_store_length: assert property (@(posedge aclk) disable iff (!aresetn)
        (period_end && lock_ok) |=> (state == ST_STORE) [*6]
        ##1 state == ST_RUN)
        else $error("store sequence length wrong");
    a_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        restart |=> half_cnt == '0 && per_cnt == 8'h00 && cnt[0] <= 1)
        else $error("restart did not clear period");
    a_period_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
        period_end |-> per_cyc + 40'h00_0000_0001 ==
        40'(prescale + 1) * 40'(HALF_SEC_CYCLES))
        else $error("period length wrong");
    a_readonly_bytes: assert property (@(posedge aclk) disable iff (!aresetn)
        ram_a_we |-> !(aw_idx >= IDX_RATE_FIRST && aw_idx <= IDX_RATE_LAST)
        && aw_idx != IDX_OVF && aw_idx != IDX_CRC_ERR)
        else $error("external write hit a result byte");
    a_stored_count: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(state == ST_STORE) |=> ram_b_dout == snap[0])
        else $error("stored count differs from snapshot");
    a_shared_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        period_end |=> cnt[0] <= 1 && cnt[4] <= 1 && ovf == '0)
        else $error("counters not cleared together");
    c_period_stored: cover property (@(posedge aclk) disable iff (!aresetn)
        store_last);
    c_restart: cover property (@(posedge aclk) disable iff (!aresetn)
        restart);
    c_overflow: cover property (@(posedge aclk) disable iff (!aresetn)
        period_end && |ovf);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule

// ==== trc_trig_src.sv ====
// Trigger line source standing in for the comparator board
`timescale 1ns/1ps
module trc_trig_src
(
    input wire logic aclk,
    input wire logic start,
    input wire logic [4:0] lanes,
    input wire logic [7:0] pulses,
    output logic [3:0] trig_patch,
    output logic trig_coinc,
    output logic busy
);
    logic [7:0] left = 8'h00;
    logic [2:0] phase = 3'h0;
    logic [4:0] mask = 5'h00;
    logic [4:0] level;
    // Pulses three cycles high, three low; lines idle low
    assign level = (busy && phase < 3'h3) ? mask : 5'h00;
    assign trig_patch = level[3:0];
    assign trig_coinc = level[4];
    assign busy = left != 8'h00;
    always_ff @(posedge aclk)
    begin
        if (start)
        begin
            left <= pulses;
            phase <= 3'h0;
            mask <= lanes;
        end
        else if (busy)
        begin
            phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            if (phase == 3'h5)
                left <= left - 8'h01;
        end
    end
endmodule

// ==== trc_top_tb.sv ====
// Self-checking testbench for the trigger rate counter
`timescale 1ns/1ps
module trc_top_tb
    import trc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic clk_locked = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, trig_coinc, src_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] trig_patch;
    logic src_start = 1'h0;
    logic [4:0] src_lanes = 5'h00;
    logic [7:0] src_pulses = 8'h00;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    trc_top #(.HALF_SEC_CYCLES(20)) trc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .trig_patch(trig_patch),
        .trig_coinc(trig_coinc), .clk_locked(clk_locked),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq));
    trc_trig_src trc_trig_src_inst (.aclk(aclk), .start(src_start),
        .lanes(src_lanes), .pulses(src_pulses), .trig_patch(trig_patch),
        .trig_coinc(trig_coinc), .busy(src_busy));
    initial
    begin
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [7:0] ra(input logic [4:0] i);
        return {1'h0, i, 2'h0};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] er;
        er = (a >= 8'h8C) ? RESP_DECERR : RESP_OKAY;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        chk($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [31:0] m = 32'hFFFFFFFF);
        logic [1:0] er;
        er = (a >= 8'h8C) ? RESP_DECERR : RESP_OKAY;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        chk($sformatf("rdata %h", a), s_axi_rdata & m, ed);
        chk($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'h0;
    endtask
    task automatic pulses(input logic [4:0] lanes, input logic [7:0] n);
        @(posedge aclk);
        src_start <= 1'h1;
        src_lanes <= lanes;
        src_pulses <= n;
        @(posedge aclk);
        src_start <= 1'h0;
        do
            @(posedge aclk);
        while (src_busy);
        repeat (6) @(posedge aclk);
    endtask
    task automatic wait_irq();
        do
            @(posedge aclk);
        while (irq !== 1'h1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic check_reset();
        rd(OFF_STATE, 32'h0);
        rd(ra(IDX_PRESCALE), {24'h0, PRESCALE_RST});
        rd(ra(IDX_RATE_FIRST), 32'h0);
        rd(8'h8C, 32'h0);
        wr(ra(IDX_DAC_FIRST), 8'h3C);
        rd(ra(IDX_DAC_FIRST), 32'h3C);
        wr(ra(IDX_SPARE), 8'h5A);
        rd(ra(IDX_SPARE), 32'h5A);
        repeat (20) @(posedge aclk);
        rd(OFF_STATE, 32'h0);
    endtask
    task automatic check_lock();
        @(posedge aclk);
        clk_locked <= 1'h1;
        repeat (10) @(posedge aclk);
        rd(OFF_STATE, 32'h3);
    endtask
    task automatic check_counts();
        logic [7:0] exp_b [10] = '{8'h05, 8'h00, 8'h02, 8'h00, 8'h03,
                                   8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
        int t0;
        wr(OFF_IRQ_MASK, 8'h07);
        wr(ra(IDX_PRESCALE), 8'h13);
        t0 = cycles;
        rd(OFF_IRQ_STAT, 32'h4, 32'h4);
        wr(OFF_IRQ_STAT, 8'h07);
        rd(OFF_IRQ_STAT, 32'h0);
        chk("irq idle", {31'h0, irq}, 32'h0);
        pulses(5'h15, 8'h03);
        pulses(5'h03, 8'h02);
        wait_irq();
        chk("period", {31'h0, cycles - t0 >= 395 &&
            cycles - t0 <= 420}, 32'h1);
        rd(OFF_IRQ_STAT, 32'h1);
        for (int i = 0; i < 10; i++)
            rd(ra(5'(IDX_RATE_FIRST + i)),
                {24'h0, exp_b[i]});
        rd(ra(IDX_OVF), 32'h0);
    endtask
    task automatic check_readonly();
        wr(ra(IDX_RATE_FIRST), 8'hAA);
        wr(ra(IDX_OVF), 8'h1F);
        rd(ra(IDX_RATE_FIRST), 32'h05);
        rd(ra(IDX_OVF), 32'h0);
        wr(8'h8C, 8'h01);
        rd(8'h8C, 32'h0);
        wr(OFF_IRQ_MASK, 8'h00);
        repeat (2) @(posedge aclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(OFF_IRQ_STAT, 8'h07);
        rd(OFF_IRQ_STAT, 32'h0);
    endtask
    task automatic check_cut_period();
        pulses(5'h01, 8'h04);
        wr(ra(IDX_PRESCALE), 8'h12);
        rd(ra(IDX_RATE_FIRST), 32'h05);
        rd(OFF_IRQ_STAT, 32'h4);
        wr(OFF_IRQ_MASK, 8'h01);
        wait_irq();
        rd(ra(IDX_RATE_FIRST), 32'h0);
    endtask
    task automatic check_lock_loss();
        @(posedge aclk);
        clk_locked <= 1'h0;
        repeat (10) @(posedge aclk);
        rd(OFF_STATE, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        check_reset();
        check_lock();
        check_counts();
        check_readonly();
        check_cut_period();
        check_lock_loss();
        tally_and_finish();
    end
endmodule
